// File: hdl/pcl_pkg.sv
// Constants and types shared by the configuration and low-power block
package pcl_pkg;
	// Bus widths
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int SECT_N = 8;  // Refresh sections, one eighth of the array each
	// Power-up values of the two configuration registers
	localparam logic [15:0] BIC_RESET = 16'h9D4F;
	localparam logic [15:0] REF_RESET = 16'h0070;
	// Address bit that picks the register during a configuration access
	localparam int SEL_BIT = 19;
	// Bus configuration fields
	localparam int BL_LSB       = 0;
	localparam int BL_W         = 3;
	localparam int WRAP_BIT     = 3;
	localparam int WAIT_CFG_BIT = 8;
	localparam int WAIT_POL_BIT = 10;
	localparam int MODE_BIT     = 15;
	// Burst length codes
	localparam logic [2:0] BL_4    = 3'h1;
	localparam logic [2:0] BL_8    = 3'h2;
	localparam logic [2:0] BL_16   = 3'h3;
	localparam logic [2:0] BL_CONT = 3'h7;
	// Refresh configuration fields
	localparam int SECT_LSB = 0;
	localparam int SECT_W   = 3;
	localparam int PDN_BIT  = 4;                 // 0 puts the die into deep power-down
	localparam logic [2:0] SECT_NONE = 3'h4;
	// Positions in the synchronised pin vector
	localparam int PIN_CE   = 22;
	localparam int PIN_WE   = 23;
	localparam int PIN_OE   = 24;
	localparam int PIN_AVL  = 25;
	localparam int PIN_CFE  = 26;
	localparam int PIN_CLK  = 27;
	localparam int PIN_W    = 28;
	// Timing
	localparam int CLK_MHZ      = 100;
	localparam int INIT_TIME_US = 150;
	localparam int INIT_CYCLES  = INIT_TIME_US * CLK_MHZ;
	localparam int IDLE_TIME_US = 10;
	localparam int IDLE_CYCLES  = IDLE_TIME_US * CLK_MHZ;
	// Power states
	typedef enum logic [2:0] {
		PCL_ACTIVE,
		PCL_STANDBY,
		PCL_LOW_POWER,
		PCL_DEEP_DOWN,
		PCL_INIT
	} pcl_pwr_t;
endpackage : pcl_pkg

// File: hdl/pcl_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pcl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         srst,
	// Pins in, synchronised copy out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] meta_reg;  // First stage, read only by the second
	genvar i;
	// One pair of flops per bit
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (srst) begin
					meta_reg[i] <= 1'b1;
					pin_sync[i] <= 1'b1;
				end else begin
					meta_reg[i] <= pin_in[i];
					pin_sync[i] <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule : pcl_sync

// File: hdl/pcl_burst_addr.sv
// Read burst address generator with wrap and rollover
`timescale 1ns/1ps
module pcl_burst_addr (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          srst,
	// Control
	input  wire logic                          load,
	input  wire logic                          step,
	input  wire logic [pcl_pkg::ADDR_W-1:0]    start_addr,
	input  wire logic [pcl_pkg::BL_W-1:0]      burst_len,
	input  wire logic                          no_wrap,
	// Current burst address
	output logic      [pcl_pkg::ADDR_W-1:0]    burst_addr
);
	import pcl_pkg::*;
	logic [ADDR_W-1:0] inc;   // Plain increment, rolls over to zero
	logic [ADDR_W-1:0] mask;  // Low bits that wrap inside the burst block
	logic [ADDR_W-1:0] nxt;
	// Wrap mask from the burst length
	always_comb begin
		inc  = burst_addr + 22'h000001;
		mask = 22'h000000;
		unique case (burst_len)
			BL_4:    mask = 22'h000003;
			BL_8:    mask = 22'h000007;
			BL_16:   mask = 22'h00000F;
			default: mask = 22'h000000;  // Continuous and reserved codes
		endcase
		// Sequential when wrap is off or continuous is chosen
		if (no_wrap || mask == 22'h000000) begin
			nxt = inc;
		end else begin
			nxt = (burst_addr & ~mask) | (inc & mask);
		end
	end
	// Address register
	always_ff @(posedge mclk) begin
		if (srst) begin
			burst_addr <= '0;
		end else if (load) begin
			burst_addr <= start_addr;
		end else if (step) begin
			burst_addr <= nxt;
		end
	end
endmodule : pcl_burst_addr

// File: hdl/pcl_top.sv
// Configuration registers and low-power control of the pseudo-static RAM die
//
// How it works
// - Chip enable high keeps die in standby
// - Idle or finished access drops into low power; pin change goes active
// - Refresh limited to chosen fraction, bottom/top
// - Refreshed ranges work; others may lose data
// - Re-included sections usable right after write
// - Deep power-down stops all refresh
// - Leaving deep power-down starts initialization wait
// - Registers load defaults, writable in any power state
// - Register enable high targets config registers
// - Register value comes on the address pins
// - Async write captures on first rising strobe
// - Address bit 19 selects which register
// - Register read drives all 16 bits out
// - Bus register powers up to its default
// - Burst length selects 4/8/16 or continuous
// - Wrap clear wraps inside aligned block
// - Continuous burst rolls over to zero
// - Mode bit picks synchronous or asynchronous
// - Polarity bit picks WAIT asserted level
// - WAIT config bit picks WAIT timing
// - Refresh register powers up to its default
// - Low three bits select refresh sections
`timescale 1ns/1ps
module pcl_top #(
	parameter int INIT_CNT = pcl_pkg::INIT_CYCLES,
	parameter int IDLE_CNT = pcl_pkg::IDLE_CYCLES
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          srst,
	// Memory bus control pins, active low unless named otherwise
	input  wire logic                          ce_n,
	input  wire logic                          we_n,
	input  wire logic                          oe_n,
	input  wire logic                          addr_valid_n,
	input  wire logic                          config_reg_enable,
	input  wire logic                          link_clk,
	// Address pins
	input  wire logic [pcl_pkg::ADDR_W-1:0]    addr,
	// Data pins, output side only
	output logic      [pcl_pkg::DATA_W-1:0]    dq_out,
	output logic                               dq_oe,
	// WAIT pin
	output logic                               wait_out,
	output logic                               wait_oe,
	// Power, refresh and mode status
	output logic                               standby,
	output logic                               low_power,
	output logic                               deep_power_down,
	output logic                               init_busy,
	output logic      [pcl_pkg::SECT_N-1:0]    refresh_mask,
	output logic                               sync_mode,
	// Read burst address
	output logic      [pcl_pkg::ADDR_W-1:0]    burst_addr
);
	import pcl_pkg::*;

	logic [PIN_W-1:0]  pin_raw;        // Pins gathered for the synchroniser
	logic [PIN_W-1:0]  pin_s;          // Synchronised pins
	logic [PIN_W-1:0]  pin_p_reg;      // Previous synchronised sample
	logic [DATA_W-1:0] bus_interface_config_reg;
	logic [DATA_W-1:0] refresh_config_reg;
	logic              wr_done_reg;    // A write already landed in this access
	pcl_pwr_t          pwr_reg;
	pcl_pwr_t          pwr_next;
	logic [13:0]       init_cnt_reg;   // Initialization countdown
	logic [13:0]       idle_cnt_reg;   // Cycles with unchanged inputs
	logic              wait_dly_reg;   // Wait request delayed by one cycle
	logic              burst_run_reg;  // A synchronous read burst is open

	// Decoded pin levels
	logic              ce_s, we_s, oe_s, avl_s, cfe_s, clk_s;
	logic              ce_p, we_p, avl_p, cfe_p, clk_p;
	logic [ADDR_W-1:0] addr_s, addr_p;
	logic              clk_rise, strobe_rise;
	logic              async_wr, sync_wr, cfg_wr;
	logic [DATA_W-1:0] wr_val;
	logic              cfg_rd;
	logic              pins_changed, op_done;
	logic              pdn_cfg, leave_pdn;
	logic              burst_load, burst_step;
	logic              wait_req, wait_asserted;

	assign pin_raw = {link_clk, config_reg_enable, addr_valid_n, oe_n, we_n, ce_n, addr};

	// Every pin passes two flops before any logic looks at it
	pcl_sync #(
		.W (PIN_W)
	) u_sync (
		.mclk     (mclk),
		.srst     (srst),
		.pin_in   (pin_raw),
		.pin_sync (pin_s)
	);

	// Previous sample, used for edge and change detection
	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_p_reg <= '1;
		end else begin
			pin_p_reg <= pin_s;
		end
	end

	assign ce_s   = pin_s[PIN_CE];
	assign we_s   = pin_s[PIN_WE];
	assign oe_s   = pin_s[PIN_OE];
	assign avl_s  = pin_s[PIN_AVL];
	assign cfe_s  = pin_s[PIN_CFE];
	assign clk_s  = pin_s[PIN_CLK];
	assign addr_s = pin_s[ADDR_W-1:0];
	assign ce_p   = pin_p_reg[PIN_CE];
	assign we_p   = pin_p_reg[PIN_WE];
	assign avl_p  = pin_p_reg[PIN_AVL];
	assign cfe_p  = pin_p_reg[PIN_CFE];
	assign clk_p  = pin_p_reg[PIN_CLK];
	assign addr_p = pin_p_reg[ADDR_W-1:0];

	// The bus clock is sampled, so it must run well below mclk
	assign clk_rise = clk_s & ~clk_p;
	// Any of the three write-closing strobes going high
	assign strobe_rise = (avl_s & ~avl_p) | (ce_s & ~ce_p) | (we_s & ~we_p);

	// Asynchronous write: value is the address held just before the first edge.
	// Byte enables are not even brought into the block.
	assign async_wr = bus_interface_config_reg[MODE_BIT] & cfe_p & ~ce_p & ~we_p
	                  & strobe_rise & ~wr_done_reg;
	// Synchronous write: taken on the bus clock edge with address valid low
	assign sync_wr = ~bus_interface_config_reg[MODE_BIT] & clk_rise & cfe_s & ~ce_s
	                 & ~we_s & ~avl_s & ~wr_done_reg;
	assign cfg_wr  = async_wr | sync_wr;
	// Register data arrives on the address pins, never on the data pins
	assign wr_val  = async_wr ? addr_p[DATA_W-1:0] : addr_s[DATA_W-1:0];

	// Register read: only the select bit of the address matters
	assign cfg_rd = cfe_s & ~ce_s & ~oe_s & we_s;

	// Only one write per access, so a later strobe edge cannot rewrite
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_done_reg <= 1'b0;
		end else if (cfg_wr) begin
			wr_done_reg <= 1'b1;
		end else if (ce_s) begin
			wr_done_reg <= 1'b0;  // Access ended
		end
	end

	// Bus configuration register, default loaded at reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			bus_interface_config_reg <= BIC_RESET;
		end else if (cfg_wr && (async_wr ? addr_p[SEL_BIT] : addr_s[SEL_BIT])) begin
			bus_interface_config_reg <= wr_val;
		end
	end

	// Refresh configuration register, default loaded at reset.
	// Writes are accepted at any time, even in deep power-down, where the host writes to leave it.
	always_ff @(posedge mclk) begin
		if (srst) begin
			refresh_config_reg <= REF_RESET;
		end else if (cfg_wr && !(async_wr ? addr_p[SEL_BIT] : addr_s[SEL_BIT])) begin
			refresh_config_reg <= wr_val;
		end
	end

	// Deep power-down is the power-down bit at zero
	assign pdn_cfg   = ~refresh_config_reg[PDN_BIT];
	// Coming back out of deep power-down needs an initialization
	assign leave_pdn = (pwr_reg == PCL_DEEP_DOWN) & ~pdn_cfg;

	// Change on any address or control pin other than the link clock wakes the die up
	assign pins_changed = (pin_s[PIN_CFE:0] != pin_p_reg[PIN_CFE:0]);
	// Rising write or output enable with the chip still selected ends an access
	assign op_done = ~ce_s & ((we_s & ~we_p) | (oe_s & ~pin_p_reg[PIN_OE]));

	// Power state choice
	always_comb begin
		pwr_next = pwr_reg;
		unique case (pwr_reg)
			PCL_DEEP_DOWN: begin
				if (leave_pdn) begin
					pwr_next = PCL_INIT;
				end
			end
			PCL_INIT: begin
				if (pdn_cfg) begin
					pwr_next = PCL_DEEP_DOWN;
				end else if (init_cnt_reg == 14'h0000) begin
					pwr_next = ce_s ? PCL_STANDBY : PCL_ACTIVE;
				end
			end
			PCL_STANDBY, PCL_ACTIVE, PCL_LOW_POWER: begin
				if (pdn_cfg) begin
					pwr_next = PCL_DEEP_DOWN;
				end else if (ce_s) begin
					pwr_next = PCL_STANDBY;
				end else if (pins_changed) begin
					pwr_next = PCL_ACTIVE;
				end else if (op_done || idle_cnt_reg == 14'(IDLE_CNT - 1)) begin
					pwr_next = PCL_LOW_POWER;
				end
			end
		endcase
	end

	// Power state register
	always_ff @(posedge mclk) begin
		if (srst) begin
			pwr_reg <= PCL_STANDBY;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	// Initialization countdown; the host must wait it out
	always_ff @(posedge mclk) begin
		if (srst) begin
			init_cnt_reg <= '0;
		end else if (leave_pdn) begin
			init_cnt_reg <= 14'(INIT_CNT - 1);
		end else if (pwr_reg == PCL_INIT && init_cnt_reg != 14'h0000) begin
			init_cnt_reg <= init_cnt_reg - 14'h0001;
		end
	end

	// Idle counter, restarted by any address or control pin change except the link clock, or by deselect; saturates at the threshold
	always_ff @(posedge mclk) begin
		if (srst) begin
			idle_cnt_reg <= '0;
		end else if (pins_changed || ce_s) begin
			idle_cnt_reg <= '0;
		end else if (idle_cnt_reg != 14'(IDLE_CNT - 1)) begin
			idle_cnt_reg <= idle_cnt_reg + 14'h0001;
		end
	end

	// Power status outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			standby         <= 1'b1;
			low_power       <= 1'b0;
			deep_power_down <= 1'b0;
			init_busy       <= 1'b0;
		end else begin
			standby         <= (pwr_next == PCL_STANDBY);
			low_power       <= (pwr_next == PCL_LOW_POWER);
			deep_power_down <= (pwr_next == PCL_DEEP_DOWN);
			init_busy       <= (pwr_next == PCL_INIT);
		end
	end

	// Refresh per eighth of the array. A section that leaves the mask may lose
	// its data; one that rejoins is refreshed from the very next cycle.
	genvar s;
	generate
		for (s = 0; s < SECT_N; s++) begin : g_sect
			logic [3:0] size;  // Sections kept by the code
			logic [2:0] psel;
			assign psel = refresh_config_reg[SECT_LSB +: SECT_W];
			assign size = (psel[1:0] == 2'h0) ? 4'h8 :
			              (psel[1:0] == 2'h1) ? 4'h4 :
			              (psel[1:0] == 2'h2) ? 4'h2 : 4'h1;
			always_ff @(posedge mclk) begin
				if (srst) begin
					refresh_mask[s] <= 1'b1;
				end else if (pdn_cfg || psel == SECT_NONE) begin
					refresh_mask[s] <= 1'b0;
				end else if (psel[2]) begin
					refresh_mask[s] <= (4'(s) >= 4'h8 - size);
				end else begin
					refresh_mask[s] <= (4'(s) < size);
				end
			end
		end
	endgenerate

	// Operating mode seen by the rest of the die
	always_ff @(posedge mclk) begin
		if (srst) begin
			sync_mode <= 1'b0;
		end else begin
			sync_mode <= ~bus_interface_config_reg[MODE_BIT];
		end
	end

	// Read burst tracking: the bus clock edge with address valid starts one
	assign burst_load = ~bus_interface_config_reg[MODE_BIT] & clk_rise & ~ce_s
	                    & ~avl_s & we_s & ~cfe_s;
	assign burst_step = clk_rise & ~ce_s & burst_run_reg & ~burst_load;

	always_ff @(posedge mclk) begin
		if (srst) begin
			burst_run_reg <= 1'b0;
		end else if (burst_load) begin
			burst_run_reg <= 1'b1;
		end else if (ce_s) begin
			burst_run_reg <= 1'b0;  // Deselect closes the burst
		end
	end

	// Length and wrap shape reads only, writes never use this address
	pcl_burst_addr u_burst (
		.mclk       (mclk),
		.srst       (srst),
		.load       (burst_load),
		.step       (burst_step),
		.start_addr (addr_s),
		.burst_len  (bus_interface_config_reg[BL_LSB +: BL_W]),
		.no_wrap    (bus_interface_config_reg[WRAP_BIT]),
		.burst_addr (burst_addr)
	);

	// Data pins carry the selected register during a register read.
	// Array data is outside this block, so otherwise they stay released.
	always_ff @(posedge mclk) begin
		if (srst) begin
			dq_out <= '0;
			dq_oe  <= 1'b0;
		end else if (cfg_rd) begin
			dq_out <= addr_s[SEL_BIT] ? bus_interface_config_reg : refresh_config_reg;
			dq_oe  <= 1'b1;
		end else begin
			dq_out <= '0;
			dq_oe  <= 1'b0;
		end
	end

	// WAIT request while the die cannot serve an access
	assign wait_req      = ~ce_s & (pwr_reg == PCL_INIT);
	// Early timing asserts with the request, late timing one cycle after
	assign wait_asserted = bus_interface_config_reg[WAIT_CFG_BIT] ? wait_req : wait_dly_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			wait_dly_reg <= 1'b0;
		end else begin
			wait_dly_reg <= wait_req;
		end
	end

	// WAIT is driven whenever the chip is selected, at the chosen polarity
	always_ff @(posedge mclk) begin
		if (srst) begin
			wait_out <= 1'b0;
			wait_oe  <= 1'b0;
		end else begin
			wait_out <= ~(wait_asserted ^ bus_interface_config_reg[WAIT_POL_BIT]);
			wait_oe  <= ~ce_s;
		end
	end
endmodule : pcl_top

// File: dv/pcl_chk.sv
// Port-level assertions for the configuration and low-power block
`timescale 1ns/1ps
module pcl_chk #(
	parameter int INIT_CNT = 20,
	parameter int IDLE_CNT = 8
) (
	// Clock and reset
	input wire logic                       mclk,
	input wire logic                       srst,
	// Bus pins
	input wire logic                       ce_n,
	input wire logic                       we_n,
	input wire logic                       oe_n,
	input wire logic                       addr_valid_n,
	input wire logic                       config_reg_enable,
	input wire logic                       link_clk,
	input wire logic [pcl_pkg::ADDR_W-1:0] addr,
	// Outputs under watch
	input wire logic                       dq_oe,
	input wire logic                       wait_oe,
	input wire logic                       standby,
	input wire logic                       low_power,
	input wire logic                       deep_power_down,
	input wire logic                       init_busy,
	input wire logic [pcl_pkg::SECT_N-1:0] refresh_mask,
	input wire logic                       sync_mode
);
	import pcl_pkg::*;
	logic [27:0] pins;    // All pin inputs, to spot any change
	int          init_n;  // Cycles spent in the init interval
	int          calm_n;  // Cycles with every pin unchanged
	int          cfe_age; // Cycles since the register enable was high
	assign pins = {ce_n, we_n, oe_n, addr_valid_n, config_reg_enable, link_clk, addr};
	// Length of the init interval
	always_ff @(posedge mclk) begin
		init_n <= (srst || !init_busy) ? 0 : init_n + 1;
	end
	// Quiet time; init and deep power-down do not count as idle
	always_ff @(posedge mclk) begin
		calm_n <= (srst || !$stable(pins) || init_busy || deep_power_down) ? 0 : calm_n + 1;
	end
	// Saturates so it never wraps in long runs
	always_ff @(posedge mclk) begin
		cfe_age <= (srst || config_reg_enable) ? 0 : (cfe_age < 15 ? cfe_age + 1 : 15);
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Five samples cover the two-flop synchroniser and the output register
	sequence s_ce_idle;
		ce_n [*5];
	endsequence
	sequence s_cfg_read;
		(config_reg_enable && !ce_n && !oe_n && we_n) [*5];
	endsequence
	standby_hold_a: assert property (s_ce_idle ##0 !(deep_power_down || init_busy || low_power) |-> standby)
		else $error("standby not shown while deselected");
	cfg_read_a: assert property (s_cfg_read |-> dq_oe)
		else $error("register read not driven");
	array_quiet_a: assert property ((!config_reg_enable) [*5] |-> !dq_oe)
		else $error("data driven without register enable");
	pdn_mask_a: assert property (deep_power_down [*2] |-> refresh_mask == 8'h00)
		else $error("refresh kept in deep power-down");
	init_len_a: assert property ($fell(init_busy) |-> init_n == INIT_CNT)
		else $error("init interval of wrong length");
	pdn_init_a: assert property ($fell(deep_power_down) |-> ##[0:1] init_busy)
		else $error("no init after deep power-down");
	wait_drive_a: assert property ((!ce_n) [*5] |-> wait_oe)
		else $error("wait not driven while enabled");
	lp_exit_a: assert property (low_power ##1 $changed(addr) |-> ##[1:5] !low_power)
		else $error("low power kept after input change");
	lp_entry_a: assert property (calm_n >= IDLE_CNT + 6 && !ce_n |-> low_power)
		else $error("low power not entered when idle");
	reg_source_a: assert property ($changed(sync_mode) |-> cfe_age < 8)
		else $error("mode changed without register access");
endmodule : pcl_chk

bind pcl_top pcl_chk #(
	.INIT_CNT(INIT_CNT),
	.IDLE_CNT(IDLE_CNT)
) i_chk (
	.mclk(mclk), .srst(srst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
	.addr_valid_n(addr_valid_n), .config_reg_enable(config_reg_enable), .link_clk(link_clk),
	.addr(addr), .dq_oe(dq_oe), .wait_oe(wait_oe), .standby(standby), .low_power(low_power),
	.deep_power_down(deep_power_down), .init_busy(init_busy), .refresh_mask(refresh_mask),
	.sync_mode(sync_mode)
);

// File: dv/pcl_host.sv
// Host memory controller model driving the die's bus pins
`timescale 1ns/1ps
module pcl_host #(
	parameter int INIT_CNT = 20
) (
	// Clock
	input  wire logic                       mclk,
	// Read data from the die
	input  wire logic [pcl_pkg::DATA_W-1:0] dq_out,
	input  wire logic                       dq_oe,
	// Bus pins
	output logic                            ce_n,
	output logic                            we_n,
	output logic                            oe_n,
	output logic                            addr_valid_n,
	output logic                            config_reg_enable,
	output logic                            link_clk,
	output logic      [pcl_pkg::ADDR_W-1:0] addr
);
	import pcl_pkg::*;
	// Strobe set after the first rise: address valid, chip enable, write enable
	localparam logic [3:0] RISE [3] = '{4'h3, 4'hA, 4'h6};
	// Deselected bus at time zero; link clock parked low outside frames
	initial begin
		{ce_n, we_n, oe_n, addr_valid_n, config_reg_enable} = 5'h1E;
		link_clk = 1'b0;
		addr = 22'h000000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// Control pins in one go: chip, write, output, address valid, register enable
	task automatic pins(input logic [4:0] v);
		{ce_n, we_n, oe_n, addr_valid_n, config_reg_enable} <= v;
	endtask : pins
	// Back to standby; address flipped so no stale value lingers
	task automatic idle();
		pins(5'h1E);
		addr <= ~addr;
		tick(4);
	endtask : idle
	// Asynchronous write; later strobes come after the address has changed
	task automatic reg_write(input logic sel, input logic [15:0] val, input logic cfe, input int first);
		pins({4'h2, cfe});
		addr <= {2'h0, sel, 3'h0, val};
		tick(5);
		pins({RISE[first], cfe});
		tick(4);
		addr <= ~addr;
		tick(2);
		idle();
	endtask : reg_write
	// Register read; address bits other than the select are junk
	task automatic reg_read(input logic sel, output logic [15:0] val);
		pins(5'h0B);
		addr <= sel ? 22'h3FFFFF : 22'h37FFFF;
		tick(6);
		val = dq_oe ? dq_out : 'x;
		idle();
	endtask : reg_read
	// One link clock period, rise first
	task automatic clk_pulse();
		link_clk <= 1'b1;
		tick(5);
		link_clk <= 1'b0;
		tick(5);
	endtask : clk_pulse
	// Synchronous single-word write; chip enable held one extra link cycle
	task automatic sync_write(input logic sel, input logic [15:0] val);
		pins(5'h05);
		addr <= {2'h0, sel, 3'h0, val};
		tick(5);
		clk_pulse();
		pins(5'h07);
		clk_pulse();
		idle();
	endtask : sync_write
	// Burst read start: address latched on the first link rise
	task automatic burst_open(input logic [21:0] start);
		pins(5'h08);
		addr <= start;
		tick(5);
		clk_pulse();
		pins(5'h0A);
		addr <= ~start;
	endtask : burst_open
	// Chip enabled, nothing else moving
	task automatic park();
		pins(5'h0E);
		tick(6);
	endtask : park
	task automatic nudge();
		addr <= ~addr;
		tick(6);
	endtask : nudge
	// No normal operation until the init interval has run out
	task automatic wake_wait();
		tick(INIT_CNT);
	endtask : wake_wait
endmodule : pcl_host

// File: dv/test_psram_config_and_low_power.sv
// Self-checking bench for the configuration and low-power block
`timescale 1ns/1ps
module test_psram_config_and_low_power;
	import pcl_pkg::*;
	localparam int INIT_N = 20; // Short init interval
	localparam int IDLE_N = 8;  // Short idle time
	// Row: register select, value written, refresh mask expected
	typedef struct {
		logic        sel;
		logic [15:0] val;
		logic [7:0]  mask;
	} pcl_row_t;
	logic                  mclk, srst;
	logic                  ce_n, we_n, oe_n, addr_valid_n, config_reg_enable, link_clk;
	logic [ADDR_W-1:0]     addr, burst_addr;
	logic [DATA_W-1:0]     dq_out, got;
	logic                  dq_oe, wait_out, wait_oe, standby, low_power, deep_power_down, init_busy, sync_mode;
	logic [SECT_N-1:0]     refresh_mask;
	int                    bad_count = 0;
	int                    n_tests = 0;
	// Bottom and top anchored sections, none, and back to full
	pcl_row_t rows [11] = '{'{1'b0, 16'h0074, 8'h00}, '{1'b0, 16'h0070, 8'hFF}, '{1'b0, 16'h0071, 8'h0F},
		'{1'b0, 16'h0072, 8'h03}, '{1'b0, 16'h0073, 8'h01}, '{1'b0, 16'h0075, 8'hF0}, '{1'b0, 16'h0076, 8'hC0},
		'{1'b0, 16'h0077, 8'h80}, '{1'b0, 16'h0070, 8'hFF}, '{1'b1, 16'h9D41, 8'hFF}, '{1'b1, 16'h9D4F, 8'hFF}};
	pcl_top #(.INIT_CNT(INIT_N), .IDLE_CNT(IDLE_N)) i_dut (
		.mclk(mclk), .srst(srst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr_valid_n(addr_valid_n),
		.config_reg_enable(config_reg_enable), .link_clk(link_clk), .addr(addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .wait_out(wait_out), .wait_oe(wait_oe), .standby(standby), .low_power(low_power),
		.deep_power_down(deep_power_down), .init_busy(init_busy), .refresh_mask(refresh_mask),
		.sync_mode(sync_mode), .burst_addr(burst_addr));
	pcl_host #(.INIT_CNT(INIT_N)) i_host (
		.mclk(mclk), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.addr_valid_n(addr_valid_n), .config_reg_enable(config_reg_enable), .link_clk(link_clk), .addr(addr));
	// Free-running system clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [21:0] exp, input logic [21:0] seen);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// Burst read of five addresses, either wrapping in a 4-word block or linear
	task automatic run_burst(input logic [21:0] start, input logic wrap4);
		logic [21:0] exp;
		i_host.burst_open(start);
		for (int k = 0; k < 5; k++) begin
			exp = wrap4 ? {start[21:2], 2'(start[1:0] + k)} : start + 22'(k);
			check("burst_addr", exp, burst_addr);
			i_host.clk_pulse();
		end
		i_host.idle();
	endtask : run_burst
	// Main sequence
	initial begin
		srst = 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		check("status", 22'h0008FF, 22'({standby, deep_power_down, init_busy, sync_mode, refresh_mask}));
		i_host.reg_read(1'b1, got);
		check("bus_cfg", 22'h009D4F, 22'(got));
		i_host.reg_read(1'b0, got);
		check("refresh_cfg", 22'h000070, 22'(got));
		foreach (rows[i]) begin
			i_host.reg_write(rows[i].sel, rows[i].val, 1'b1, i % 3);
			check("mask", 22'(rows[i].mask), 22'(refresh_mask));
			i_host.reg_read(rows[i].sel, got);
			check("readback", 22'(rows[i].val), 22'(got));
		end
		// Register enable low: the write goes to the array instead
		i_host.reg_write(1'b0, 16'h0074, 1'b0, 2);
		i_host.reg_read(1'b0, got);
		check("refresh_kept", 22'h000070, 22'(got));
		// Deep power-down and wake-up under both WAIT polarities
		for (int p = 1; p >= 0; p--) begin
			i_host.reg_write(1'b1, p[0] ? 16'h9D4F : 16'h984F, 1'b1, 1);
			i_host.reg_write(1'b0, 16'h0060, 1'b1, 2);
			check("deep_down", 22'h000100, 22'({deep_power_down, refresh_mask}));
			i_host.reg_write(1'b0, 16'h0070, 1'b1, 0);
			i_host.park();
			check("init_wait", 22'({2'h3, p[0]}), 22'({init_busy, wait_oe, wait_out}));
			i_host.wake_wait();
			check("awake", 22'({1'b0, !p[0], 8'hFF}), 22'({init_busy, wait_out, refresh_mask}));
			i_host.tick(IDLE_N + 10);
			check("low_power", 22'h1, 22'(low_power));
			i_host.nudge();
			check("woken", 22'h0, 22'(low_power));
			i_host.idle();
		end
		i_host.reg_write(1'b1, 16'h1D41, 1'b1, 0);
		check("sync_mode", 22'h1, 22'(sync_mode));
		run_burst(22'h000106, 1'b1);
		i_host.sync_write(1'b1, 16'h1D4F);
		i_host.reg_read(1'b1, got);
		check("bus_cfg_sync", 22'h001D4F, 22'(got));
		run_burst(22'h3FFFFE, 1'b0);
		i_host.sync_write(1'b1, 16'h9D4F);
		check("async_back", 22'h0, 22'(sync_mode));
		print_verdict();
	end
	// Hang guard, far beyond the fewer than one thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end
endmodule : test_psram_config_and_low_power
